// ### swk_defs.vh
// Purpose: Constants for the selective wake control register bank
// Assumes: Wishbone classic slave, 32-bit data, byte addresses = 4 x register index
// Notes:   Register indices are kept as printed; reserved bits read zero
//
// Functional notes
// - Control bit 7 enables oscillator calibration mode when one.
// - Unlock field bits 6:5 unlocks only at 11; other patterns stay locked.
// - Calibration uses the CAN transmit-data input pin as trimming reference.
// - Unlock 11 also allows writes to the wake option register; else blocked.
// - Timeout mask bit 4 one lets a bus timeout reach the interrupt.
// - Timeout flag updates only while selective wake mode bit set; timeout status event also needs Normal/Stop.
// - Host verifies config then sets valid bit 0; wake enabled only while one.
// - Device clears valid bit on wake-up, power-on, or config data change.
// - Control resets to zero; restart keeps upper nibble, clears lower nibble.
// - Control bits 3:1 and sample-point bits 7:6 always read zero.
// - Quanta register holds eight-bit count; reset A0, restart unchanged.
// - Quantum length depends on two-bit oscillator clock select input.
// - Sample point six-bit fraction; reset 33 (0.796875), restart unchanged.
`ifndef SWK_DEFS_VH
`define SWK_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SWK_IDX_CTRL        8'h20
`define SWK_IDX_QUANTA      8'h21
`define SWK_IDX_SAMPLE      8'h22
`define SWK_IDX_OPTION      8'h30
`define SWK_IDX_IRQ_STAT    8'h31
`define SWK_IDX_IRQ_MASK    8'h32
`define SWK_IDX_STATUS      8'h33

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WAKE_CONTROL_CAL_BIT    7
`define WAKE_CONTROL_UNLK_HI    6
`define WAKE_CONTROL_UNLK_LO    5
`define WAKE_CONTROL_TOMASK_BIT 4
`define WAKE_CONTROL_VALID_BIT  0
`define SWK_UNLOCK_KEY      2'h3

// ----------------------------------------------------------------
// Write masks and reset values
// ----------------------------------------------------------------
`define WAKE_CONTROL_WMASK      8'hF1
`define WAKE_CONTROL_RESTART_M  8'hF0
`define SWK_SAMPLE_WMASK    8'h3F
`define SWK_OPTION_WMASK    8'h01
`define WAKE_CONTROL_RST        8'h00
`define SWK_QUANTA_RST      8'hA0
`define SWK_SAMPLE_RST      8'h33
`define SWK_OPTION_RST      8'h00

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define SWK_IRQ_TIMEOUT     0
`define SWK_IRQ_INVALID     1
`define SWK_IRQ_W           2

`endif

// ### swk_regs.v
// Purpose: Selective wake control, bit timing and option registers
// Assumes: Single clock, synchronous active-high reset, all inputs synchronous
// Notes:   Reset = power-on or soft reset; restart_i is a one-cycle pulse
`include "swk_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module swk_regs
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        restart_i,
    input  wire        wake_event_i,
    input  wire        bus_timeout_i,
    input  wire        wake_mode_en_i,
    input  wire        mode_normal_or_stop_i,
    input  wire [1:0]  osc_clock_select_i,
    input  wire        can_tx_input_pin_i,
    input  wire        cfg_changed_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    output wire        osc_calib_mode_o,
    output wire        calib_unlocked_o,
    output wire        calib_ref_o,
    output wire        wake_cfg_valid_o,
    output wire        selective_wake_en_o,
    output wire [7:0]  quanta_per_bit_o,
    output wire [5:0]  sample_point_frac_o,
    output wire [1:0]  quantum_clk_sel_o,
    output wire        alt_receiver_en_o,
    output reg         bus_timeout_flag_o,
    output wire        irq_o
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg  [7:0]             ctrl_reg;
reg  [7:0]             quanta_reg;
reg  [7:0]             sample_reg;
reg  [7:0]             option_reg;
reg  [`SWK_IRQ_W-1:0]  istat_reg;
reg  [`SWK_IRQ_W-1:0]  imask_reg;
reg  [7:0]             ctrl_next;
reg  [31:0]            rdata;
reg                    hit;

wire       req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
wire       wr      = req && wb_we_i && wb_sel_i[0];
wire [7:0] wdat    = wb_dat_i[7:0];
wire       wr_ctrl = wr && (wb_adr_i[7:2] == `SWK_IDX_CTRL);
wire       wr_qnt  = wr && (wb_adr_i[7:2] == `SWK_IDX_QUANTA);
wire       wr_smp  = wr && (wb_adr_i[7:2] == `SWK_IDX_SAMPLE);
wire       wr_opt  = wr && (wb_adr_i[7:2] == `SWK_IDX_OPTION);

wire unlocked = (ctrl_reg[`WAKE_CONTROL_UNLK_HI:`WAKE_CONTROL_UNLK_LO] == `SWK_UNLOCK_KEY);

wire cfg_touch = wr_qnt || wr_smp || (wr_opt && unlocked) || cfg_changed_i;

// timeout status event only follows timeouts while wake mode on in Normal/Stop
wire timeout_ev = bus_timeout_i && wake_mode_en_i && mode_normal_or_stop_i;

// Valid bit dropping by hardware is itself a status event
wire invalidate = ctrl_reg[`WAKE_CONTROL_VALID_BIT] && (wake_event_i || cfg_touch || restart_i);

// ----------------------------------------------------------------
// Control register next value
// ----------------------------------------------------------------
always @*
begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
        ctrl_next = wdat & `WAKE_CONTROL_WMASK;
    end
    // automatic valid clear wins over host set
    if (wake_event_i || cfg_touch)
    begin
        ctrl_next[`WAKE_CONTROL_VALID_BIT] = 1'b0;
    end
    if (restart_i)
    begin
        ctrl_next = ctrl_reg & `WAKE_CONTROL_RESTART_M;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ctrl_reg   <= `WAKE_CONTROL_RST;
        quanta_reg <= `SWK_QUANTA_RST;
        sample_reg <= `SWK_SAMPLE_RST;
        option_reg <= `SWK_OPTION_RST;
    end
    else
    begin
        ctrl_reg <= ctrl_next;
        if (wr_qnt)
        begin
            quanta_reg <= wdat;
        end
        if (wr_smp)
        begin
            sample_reg <= wdat & `SWK_SAMPLE_WMASK;
        end
        if (wr_opt && unlocked)
        begin
            option_reg <= wdat & `SWK_OPTION_WMASK;
        end
    end
end

// ----------------------------------------------------------------
// Timeout flag and interrupts
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        bus_timeout_flag_o <= 1'b0;
        istat_reg          <= {`SWK_IRQ_W{1'b0}};
        imask_reg          <= {`SWK_IRQ_W{1'b0}};
    end
    else
    begin
        if (wake_mode_en_i)
        begin
            bus_timeout_flag_o <= bus_timeout_i;
        end
        // Set wins over write-one-to-clear
        istat_reg <= (istat_reg & ~((wr && (wb_adr_i[7:2] == `SWK_IDX_IRQ_STAT)) ?
                     wdat[`SWK_IRQ_W-1:0] : {`SWK_IRQ_W{1'b0}}))
                     | {invalidate, timeout_ev};
        if (wr && (wb_adr_i[7:2] == `SWK_IDX_IRQ_MASK))
        begin
            imask_reg <= wdat[`SWK_IRQ_W-1:0];
        end
    end
end

// timeout reaches pin only with control mask bit set
wire [`SWK_IRQ_W-1:0] gate = imask_reg &
     {1'b1, ctrl_reg[`WAKE_CONTROL_TOMASK_BIT]};
assign irq_o = |(istat_reg & gate);

// ----------------------------------------------------------------
// Bus read and answer
// ----------------------------------------------------------------
always @*
begin
    hit   = 1'b1;
    rdata = 32'h00000000;
    case (wb_adr_i[7:2])
        `SWK_IDX_CTRL:     rdata[7:0] = ctrl_reg;
        `SWK_IDX_QUANTA:   rdata[7:0] = quanta_reg;
        `SWK_IDX_SAMPLE:   rdata[7:0] = sample_reg;
        `SWK_IDX_OPTION:   rdata[7:0] = option_reg;
        `SWK_IDX_IRQ_STAT: rdata[`SWK_IRQ_W-1:0] = istat_reg;
        `SWK_IDX_IRQ_MASK: rdata[`SWK_IRQ_W-1:0] = imask_reg;
        `SWK_IDX_STATUS:   rdata[3:0] = {unlocked, wake_mode_en_i, bus_timeout_flag_o, selective_wake_en_o};
        default:           hit = 1'b0;
    endcase
end

// One-cycle answer; unmapped addresses get err
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_err_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end
    else
    begin
        wb_ack_o <= req && hit;
        wb_err_o <= req && !hit;
        wb_dat_o <= (req && hit && !wb_we_i) ? rdata : 32'h00000000;
    end
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
// calibration mode bit
assign osc_calib_mode_o    = ctrl_reg[`WAKE_CONTROL_CAL_BIT];
assign calib_unlocked_o    = unlocked;
// transmit pin as trimming reference while calibrating and unlocked
assign calib_ref_o         = ctrl_reg[`WAKE_CONTROL_CAL_BIT] && unlocked && can_tx_input_pin_i;
assign wake_cfg_valid_o    = ctrl_reg[`WAKE_CONTROL_VALID_BIT];
assign selective_wake_en_o = ctrl_reg[`WAKE_CONTROL_VALID_BIT] && wake_mode_en_i;
assign quanta_per_bit_o    = quanta_reg;
assign sample_point_frac_o = sample_reg[5:0];
// quantum length follows oscillator clock select
assign quantum_clk_sel_o   = osc_clock_select_i;
assign alt_receiver_en_o   = option_reg[0];

endmodule
`default_nettype wire

// ### swk_regs_sva.sv
// Purpose: port checks for swk_regs
// Assumes: one clock, sync active-high reset
// Notes: the host model always drives every byte select
`timescale 1ns/1ps
`default_nettype none
module swk_regs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic wake_event_i,
    input wire logic wake_mode_en_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic calib_unlocked_o,
    input wire logic wake_cfg_valid_o,
    input wire logic selective_wake_en_o,
    input wire logic [7:0] quanta_per_bit_o,
    input wire logic bus_timeout_flag_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // A held request is not taken again while its ack is out
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wt = tk & wb_we_i;
    wire [1:0] key = wb_dat_i[6:5];
    unlock_key_a: assert property (wt && wb_adr_i == 8'h80 && !restart_i
        |=> calib_unlocked_o == ($past(key) == 2'h3)) else $error("unlock wrong");
    wake_en_a: assert property (selective_wake_en_o == (wake_cfg_valid_o && wake_mode_en_i))
        else $error("wake enable wrong");
    valid_clr_a: assert property (wake_event_i |=> !wake_cfg_valid_o)
        else $error("valid kept");
    restart_keep_a: assert property (restart_i |=> !wake_cfg_valid_o && $stable(calib_unlocked_o))
        else $error("restart wrong");
    flag_gate_a: assert property (!wake_mode_en_i |=> $stable(bus_timeout_flag_o))
        else $error("flag moved");
    quanta_keep_a: assert property (!(wt && wb_adr_i == 8'h84) |=> $stable(quanta_per_bit_o))
        else $error("quanta moved");
    ctrl_rsv_a: assert property (tk && !wb_we_i && wb_adr_i == 8'h80
        |=> wb_ack_o && wb_dat_o[31:8] == 24'h0 && wb_dat_o[3:1] == 3'h0) else $error("ctrl reserved");
    sample_rsv_a: assert property (tk && !wb_we_i && wb_adr_i == 8'h88
        |=> wb_ack_o && wb_dat_o[31:6] == 26'h0) else $error("sample reserved");
    cover property (wt && wb_adr_i == 8'h80);
    cover property (restart_i);
    cover property (wake_event_i);
endmodule
bind swk_regs swk_regs_chk chk (.*);
`default_nettype wire

// ### swk_host.sv
// Purpose: host model, classic Wishbone master
// Assumes: slave answers each request with ack or err
// Notes: idle address and data show inverted values; we and sel keep their last values
`timescale 1ns/1ps
`default_nettype none
module swk_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] rdat_i,
    output var  logic        cyc_o = 1'b0,
    output var  logic        stb_o = 1'b0,
    output var  logic        we_o = 1'b0,
    output var  logic [7:0]  adr_o = 8'h00,
    output var  logic [31:0] dat_o = 32'h0,
    output var  logic [3:0]  sel_o = 4'h0
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        sel_o <= 4'hF;
        do
            @(posedge clk_i);
        while (!(ack_i || err_i));
        q = rdat_i;
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ### swk_tb.sv
// Purpose: self-checking bench for swk_regs
// Assumes: swk_host owns the register bus
// Notes: random register data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, restart_i = 1'b0, wake_event_i = 1'b0, cfg_changed_i = 1'b0;
    logic bus_timeout_i = 1'b0, wake_mode_en_i = 1'b0, mode_normal_or_stop_i = 1'b1, can_tx_input_pin_i = 1'b0;
    logic [1:0] osc_clock_select_i = 2'h0;
    wire wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, osc_calib_mode_o, calib_unlocked_o, calib_ref_o;
    wire wake_cfg_valid_o, selective_wake_en_o, alt_receiver_en_o, bus_timeout_flag_o, irq_o;
    wire [7:0] wb_adr_i, quanta_per_bit_o;
    wire [31:0] wb_dat_i, wb_dat_o;
    wire [3:0] wb_sel_i;
    wire [5:0] sample_point_frac_o;
    wire [1:0] quantum_clk_sel_o;
    int err_total = 0, comparisons = 0, i;
    logic [31:0] q, d;
    logic [7:0] a;
    logic e;
    swk_regs uut (.*);
    swk_host host (.clk_i, .ack_i(wb_ack_o), .err_i(wb_err_o), .rdat_i(wb_dat_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .dat_o(wb_dat_i), .sel_o(wb_sel_i));
    always #5 clk_i = ~clk_i;
    task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] dd);
        host.xfer(w, ad, dd, q, e);
        if (!w)
            ck("read data", dd, q);
    endtask
    function automatic logic [31:0] rmask(input logic [7:0] ad, input logic [7:0] dd);
        return {24'h0, dd & (ad == 8'h80 ? 8'hF1 : ad == 8'h88 ? 8'h3F : 8'hFF)};
    endfunction
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #50us;
        err_total++;
        finish_test;
    end
    initial
    begin
        void'($urandom(37723));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, 8'h80, 32'h0);
        acc(0, 8'h84, 32'hA0);
        acc(0, 8'h88, 32'h33);
        host.xfer(1'b0, 8'hFC, 32'h0, q, e);
        ck("unmapped error", 32'h1, 32'(e));
        for (i = 0; i < 12; i++)
        begin
            osc_clock_select_i <= 2'(i);
            a = 8'h80 + 8'(4 * (i % 3));
            d = (i < 3) ? 32'hFFFFFFFF : $urandom;
            acc(1, a, d);
            acc(0, a, rmask(a, d[7:0]));
            ck("clock select", 32'(i % 4), 32'(quantum_clk_sel_o));
        end
        can_tx_input_pin_i <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            acc(1, 8'h80, 32'h80 | 32'(i << 5));
            acc(1, 8'hC0, 32'h1);
            ck("unlock outputs", {1'b1, {3{i == 3}}}, {osc_calib_mode_o, calib_unlocked_o, calib_ref_o, alt_receiver_en_o});
            acc(1, 8'hC0, 32'h0);
        end
        wake_mode_en_i <= 1'b1;
        for (i = 0; i < 3; i++)
        begin
            acc(1, 8'h80, 32'h1);
            ck("wake enable", 32'h1, 32'(selective_wake_en_o));
            if (i == 0)
                acc(1, 8'h84, 32'h5A);
            @(posedge clk_i);
            wake_event_i <= (i == 1);
            cfg_changed_i <= (i == 2);
            @(posedge clk_i);
            wake_event_i <= 1'b0;
            cfg_changed_i <= 1'b0;
            @(negedge clk_i);
            ck("valid", 32'h0, 32'(wake_cfg_valid_o));
        end
        acc(1, 8'hC8, 32'h1);
        acc(1, 8'h80, 32'hF1);
        @(posedge clk_i);
        restart_i <= 1'b1;
        @(posedge clk_i);
        restart_i <= 1'b0;
        acc(0, 8'h80, 32'hF0);
        acc(0, 8'h84, 32'h5A);
        ck("quanta out", 32'h5A, 32'(quanta_per_bit_o));
        ck("sample out", 32'(d[5:0]), 32'(sample_point_frac_o));
        for (i = 0; i < 4; i++)
        begin
            acc(1, 8'h80, (i > 0) ? 32'h10 : 32'h0);
            @(posedge clk_i);
            wake_mode_en_i <= (i != 2);
            mode_normal_or_stop_i <= (i != 3);
            bus_timeout_i <= 1'b1;
            @(posedge clk_i);
            bus_timeout_i <= 1'b0;
            @(negedge clk_i);
            ck("irq and flag", {i == 1, i != 2}, {irq_o, bus_timeout_flag_o});
            acc(1, 8'hC4, 32'h1);
        end
        ck("irq cleared", 32'h0, 32'(irq_o));
        finish_test;
    end
endmodule
`default_nettype wire
